// [hdl/oscc_pkg.sv]
/*
 Constants for the oscillator and PLL control block.
 Assumes a single 25 MHz clock and plain control ports.
*/
package oscc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned PLL_SETTLE_NS   = 30_000;
    localparam int unsigned PLL_SETTLE_CYC  = (PLL_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned PLL_LOCK_CYC    = 16;
    localparam int unsigned SLOW_SYNC_CYC   = 2;
    // ------------------------------------------------------------
    // Field widths and values
    // ------------------------------------------------------------
    localparam int unsigned LOCK_MASK_W     = 6;
    localparam int unsigned CAL_W           = 10;
    localparam logic [31:0] UNLOCK_KEY      = 32'h05A5_A5A6;
    localparam logic [9:0]  CAL_RESET       = 10'h000;
    localparam logic [9:0]  CAL_NOMINAL     = 10'h200;
endpackage : oscc_pkg

// [hdl/oscc_ctrl.sv]
/*
 Oscillator and PLL control: slow RC enable and pin output, PLL enable and lock,
 lock-mask counter, system RC trim, and the write-unlock trigger.
 Assumes software drives the control ports on clk; pll_locked_in and wake_in are
 asynchronous and are synchronised here.
*/
// How it works
// - The slow RC pin output follows the power manager bit while the slow RC is enabled, and drops on the next clk edge after the bit clears.
// - A lock indication may otherwise persist after the PLL is disabled, sending a wrong clock out.
// - A nonzero lock-mask count makes the internal PLL enable glitch on asynchronous wake-up.
// - The system RC trim resets uncalibrated, so the oscillator runs fast near 150 kHz.
// - A write of the key value to any address of the block sets the write-unlock.
`timescale 1ns/1ps
module oscc_ctrl #(
    parameter int unsigned LOCK_MASK_W = oscc_pkg::LOCK_MASK_W,
    parameter int unsigned CAL_W       = oscc_pkg::CAL_W
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   wr_en,
    input  wire logic [31:0]            wr_data,
    input  wire logic                   slow_rc_en_req,
    input  wire logic                   slow_rc_pin_output,
    input  wire logic                   pll_en_req,
    input  wire logic [LOCK_MASK_W-1:0] pll_lock_mask_count,
    input  wire logic                   cal_wr,
    input  wire logic [CAL_W-1:0]       cal_data,
    input  wire logic                   wake_in,
    input  wire logic                   pll_locked_in,
    input  wire logic                   unlock_clr,
    output logic                        slow_rc_en_status,
    output logic                        slow_rc_pin,
    output logic                        pll_enable_signal,
    output logic                        pll_lock_flag,
    output logic                        pll_settled,
    output logic [CAL_W-1:0]            system_rc_cal_reg,
    output logic                        unlock
);
    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [1:0] slow_sync;
    logic [1:0] lock_sync;
    logic [1:0] wake_sync;
    logic       wake_prev;
    // The enable request is on clk already; its two stages stand for the oscillator's own domain.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_sync <= 2'h0;
        end else begin
            slow_sync <= {slow_sync[0], slow_rc_en_req};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_sync <= 2'h0;
        end else begin
            lock_sync <= {lock_sync[0], pll_locked_in};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_sync <= 2'h0;
        end else begin
            wake_sync <= {wake_sync[0], wake_in};
        end
    end

    // Resets low like the idle wake pin, so no false wake follows reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_prev <= 1'b0;
        end else begin
            wake_prev <= wake_sync[1];
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire wake_edge   = wake_sync[1] && !wake_prev;
    wire mask_active = pll_lock_mask_count != '0;
    wire key_hit     = wr_en && (wr_data == oscc_pkg::UNLOCK_KEY);
    // A nonzero mask count drops the enable for one cycle at wake-up, as the silicon does.
    wire glitch      = wake_edge && mask_active;
    wire next_pll_en = pll_en_req && !glitch;
    wire pll_rise    = next_pll_en && !pll_enable_signal;
    // Slow RC drives the pin only while both the oscillator and the pin bit are on.
    wire next_pin    = slow_rc_pin_output && slow_sync[1];

    // ------------------------------------------------------------
    // Slow RC and trim
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_rc_en_status <= 1'b0;
        end else begin
            slow_rc_en_status <= slow_sync[1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_rc_pin <= 1'b0;
        end else begin
            slow_rc_pin <= next_pin;
        end
    end

    // The trim is not self-calibrating; only software can bring it to nominal.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            system_rc_cal_reg <= oscc_pkg::CAL_RESET[CAL_W-1:0];
        end else if (cal_wr) begin
            system_rc_cal_reg <= cal_data;
        end
    end

    // ------------------------------------------------------------
    // Unlock
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unlock <= 1'b0;
        end else if (key_hit) begin
            unlock <= 1'b1;
        end else if (unlock_clr) begin
            unlock <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // PLL enable, lock and settle timer
    // ------------------------------------------------------------
    localparam int unsigned SETTLE_W = $clog2(oscc_pkg::PLL_SETTLE_CYC + 1);
    localparam int unsigned LOCK_W   = $clog2(oscc_pkg::PLL_LOCK_CYC + 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(oscc_pkg::PLL_SETTLE_CYC);
    localparam logic [LOCK_W-1:0]   LOCK_DONE   = LOCK_W'(oscc_pkg::PLL_LOCK_CYC);
    logic [SETTLE_W-1:0] settle_cnt;
    logic [LOCK_W-1:0]   lock_cnt;
    // Any disable or fresh enable restarts both the settle and the lock timing.
    wire                restart       = !next_pll_en || pll_rise;
    wire                settle_done   = settle_cnt == '0;
    wire                lock_full     = lock_cnt == LOCK_DONE;
    wire [SETTLE_W-1:0] next_settle   = restart ? SETTLE_LOAD
                                      : (settle_done ? settle_cnt : settle_cnt - 1'b1);
    wire [LOCK_W-1:0]   next_lock_cnt = (restart || !lock_sync[1]) ? '0
                                      : (lock_full ? lock_cnt : lock_cnt + 1'b1);
    wire                next_settled  = !restart && settle_done;
    wire                next_lock     = !restart && lock_sync[1] && lock_full;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_enable_signal <= 1'b0;
        end else begin
            pll_enable_signal <= next_pll_en;
        end
    end

    // Clearing on every disable stops a stale lock from leaking onward.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_lock_flag <= 1'b0;
        end else begin
            pll_lock_flag <= next_lock;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_settled <= 1'b0;
        end else begin
            pll_settled <= next_settled;
        end
    end

    // The settle count holds at zero rather than wrapping, so settled stays up.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt <= '0;
        end else begin
            settle_cnt <= next_settle;
        end
    end

    // A dropout of the raw lock restarts the debounce; a noisy lock never reaches the flag.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt <= '0;
        end else begin
            lock_cnt <= next_lock_cnt;
        end
    end
endmodule : oscc_ctrl

// [test/oscc_monitor.sv]
/* Checks on the oscillator and PLL control ports.
   Sees only the ports of oscc_ctrl; bound to it below. */
`timescale 1ns/1ps
module oscc_monitor #(
    parameter int unsigned LOCK_MASK_W = 6,
    parameter int unsigned CAL_W       = 10
) (
    input wire logic clk, rst_n, wr_en, slow_rc_en_req, slow_rc_pin_output, pll_en_req,
    input wire logic cal_wr, wake_in, pll_locked_in, unlock_clr, slow_rc_en_status,
    input wire logic slow_rc_pin, pll_enable_signal, pll_lock_flag, pll_settled, unlock,
    input wire logic [31:0]            wr_data,
    input wire logic [LOCK_MASK_W-1:0] pll_lock_mask_count,
    input wire logic [CAL_W-1:0]       cal_data, system_rc_cal_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pin_gated: assert property (!slow_rc_pin_output && !$past(slow_rc_pin_output)
        |-> !slow_rc_pin) else $error("pin driven with output bit clear");
    a_sync_three: assert property (slow_rc_en_status == $past(slow_rc_en_req, 3))
        else $error("enable status not three edges behind request");
    a_lock_drops: assert property (!pll_en_req |=> !pll_lock_flag && !pll_settled)
        else $error("lock or settled kept after disable");
    a_lock_needs_en: assert property (pll_lock_flag |-> pll_enable_signal)
        else $error("lock flag without enable");
    a_no_glitch: assert property (pll_en_req && $past(pll_en_req)
        && $past(pll_lock_mask_count) == 0 |-> pll_enable_signal) else $error("enable glitch");
    a_key_unlocks: assert property (wr_en && wr_data == oscc_pkg::UNLOCK_KEY |=> unlock)
        else $error("key write did not unlock");
    a_unlock_sticky: assert property (unlock && !unlock_clr |=> unlock)
        else $error("unlock dropped by itself");
    a_trim_load: assert property (cal_wr |=> system_rc_cal_reg == $past(cal_data))
        else $error("trim not loaded");
    c_settled: cover property (pll_settled);
    c_unlock: cover property ($rose(unlock));
    c_glitch: cover property ($fell(pll_enable_signal) && pll_en_req);
endmodule : oscc_monitor
bind oscc_ctrl oscc_monitor #(.LOCK_MASK_W(LOCK_MASK_W), .CAL_W(CAL_W)) u_mon (.*);

// [test/testbench.sv]
/* Self-checking bench for oscc_ctrl.
   The bench drives every input itself; there is no partner model. */
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst_n = 0, wr_en = 0, slow_rc_en_req = 0, slow_rc_pin_output = 0;
    logic pll_en_req = 0, cal_wr = 0, wake_in = 0, pll_locked_in = 0, unlock_clr = 0;
    logic slow_rc_en_status, slow_rc_pin, pll_enable_signal, pll_lock_flag, pll_settled, unlock;
    logic [31:0] wr_data = 32'h0000_0000;
    logic [5:0]  pll_lock_mask_count = 6'h00;
    logic [9:0]  cal_data = 10'h000, system_rc_cal_reg;
    int          failures = 0, n_compared = 0;
    oscc_ctrl dut (.*);
    always #20 clk = ~clk;
    task automatic results;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cy(input int n);
        repeat (n) @(posedge clk);
    endtask : cy
    // A wait that runs out of cycles ends the run; a hang would hide every later check.
    task automatic wt(ref logic s, input logic v, input int n);
        repeat (n) begin
            @(negedge clk);
            if (s === v) return;
        end
        failures++;
        results();
    endtask : wt
    initial begin
        cy(3);
        rst_n <= 1;
        @(negedge clk) chk({unlock, pll_lock_flag, pll_settled, slow_rc_pin}, 0);
        chk(system_rc_cal_reg, oscc_pkg::CAL_RESET);
        cy(1);
        slow_rc_en_req <= 1;
        cy(2);
        @(negedge clk) chk(slow_rc_en_status, 0);
        wt(slow_rc_en_status, 1, 8);
        chk(slow_rc_pin, 0);
        cy(1);
        slow_rc_pin_output <= 1;
        cy(2);
        @(negedge clk) chk(slow_rc_pin, 1);
        cy(1);
        slow_rc_pin_output <= 0;
        slow_rc_en_req <= 0;
        wt(slow_rc_en_status, 0, 8);
        chk(slow_rc_pin, 0);
        cy(1);
        wr_en <= 1;
        wr_data <= 32'h5A5A_5A5A;
        cy(1);
        wr_data <= oscc_pkg::UNLOCK_KEY;
        @(negedge clk) chk(unlock, 0);
        cy(1);
        wr_en <= 0;
        unlock_clr <= 1;
        @(negedge clk) chk(unlock, 1);
        cy(1);
        unlock_clr <= 0;
        cal_wr <= 1;
        cal_data <= oscc_pkg::CAL_NOMINAL;
        @(negedge clk) chk(unlock, 0);
        cy(1);
        cal_wr <= 0;
        pll_en_req <= 1;
        pll_locked_in <= 1;
        @(negedge clk) chk(system_rc_cal_reg, oscc_pkg::CAL_NOMINAL);
        wt(pll_lock_flag, 1, 40);
        cy(700);
        @(negedge clk) chk(pll_settled, 0);
        wt(pll_settled, 1, 60);
        cy(1);
        pll_en_req <= 0;
        cy(1);
        @(negedge clk) chk({pll_lock_flag, pll_settled, pll_enable_signal}, 0);
        cy(1);
        pll_lock_mask_count <= 6'h01;
        pll_en_req <= 1;
        cy(4);
        wake_in <= 1;
        wt(pll_enable_signal, 0, 8);
        cy(1);
        pll_lock_mask_count <= 6'h00;
        wt(pll_enable_signal, 1, 8);
        chk(pll_lock_flag, 0);
        cy(1);
        wake_in <= 0;
        cy(4);
        wr_en <= 1;
        unlock_clr <= 1;
        wake_in <= 1;
        cy(1);
        wr_en <= 0;
        unlock_clr <= 0;
        @(negedge clk) chk(unlock, 1);
        cy(6);
        @(negedge clk) chk(pll_enable_signal, 1);
        results();
    end
endmodule : testbench
